/* hdl/sar_adc_ctrl.sv */
// Control and serial readout of an 18-bit successive-approximation converter.
// Function
// RULE_01 - Convert strobe rising edge starts conversion
// RULE_02 - Busy high during conversion only
// RULE_03 - Cascade select low: pin enables output
// RULE_04 - Cascade select high: pin is data in
// RULE_05 - Shift out MSB first per SCK rise
// RULE_06 - Result is two's complement
// RULE_07 - Result code is 18 bits
// RULE_08 - Search one bit per step, MSB down
// RULE_09 - Finished code loaded into output path
// RULE_10 - Internal timer times conversion
// RULE_11 - Result readable right after conversion
// RULE_12 - Nap between conversions
// RULE_13 - Track input outside conversion
// RULE_14 - Host keeps SCK quiet after strobe
// RULE_15 - Output enabled when read enable low
// RULE_16 - Next bit after each SCK rise
// RULE_17 - MSB present before first SCK rise
// RULE_18 - Output released when read enable high
// RULE_19 - Cascade data follows own word
`timescale 1ns/1ps
`include "sar_adc_defs.svh"
module sar_adc_ctrl
    import sar_adc_pkg::*;
(
    // Clock and reset.
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    // Host pins.
    input  wire logic                     convert_strobe,
    input  wire logic                     cascade_select,
    input  wire logic                     read_enable_or_cascade_in,
    input  wire logic                     sck,
    input  wire logic                     comparator_high,
    // Serial data output as two signals, and the busy flag.
    output logic                          sdo_out,
    output logic                          sdo_oe,
    output logic                          busy,
    // Analog front end control.
    output logic [`RESULT_WIDTH-1:0]      capacitive_dac,
    output logic                          track,
    output logic                          nap
);
    localparam int W = `RESULT_WIDTH;
    localparam int CONV_CYC = `CONV_CYCLES;

    logic cnv_rise;
    logic sck_rise;
    logic pin_low;
    logic pin_lvl;

    // Synchronised strobe, shift clock and shared pin.
    edge_sync u_cnv (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in (convert_strobe),
        .level    (),
        .rise     (cnv_rise)
    );
    edge_sync u_sck (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in (sck),
        .level    (),
        .rise     (sck_rise)
    );
    edge_sync u_pin (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in (~read_enable_or_cascade_in),
        .level    (pin_low),
        .rise     ()
    );

    // The pin enters inverted, so the reset value of the stages reads as a
    // high, released pin and no false enable follows reset.
    assign pin_lvl = ~pin_low;

    logic sel_meta;
    logic sel_sync;
    logic next_sel_meta;
    logic next_sel_sync;

    // Mode pin synchroniser; modes switch only between frames in practice.
    always_comb begin
        next_sel_meta = cascade_select;
        next_sel_sync = sel_meta;
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
        end else begin
            sel_meta <= next_sel_meta;
            sel_sync <= next_sel_sync;
        end
    end

    conv_state_t          state;
    conv_state_t          next_state;
    logic [W-1:0]         trial;
    logic [W-1:0]         next_trial;
    logic [W-1:0]         bit_mask;
    logic [W-1:0]         next_bit_mask;
    logic [9:0]           timer;
    logic [9:0]           next_timer;
    logic [1:0]           step;
    logic [1:0]           next_step;
    logic [W-1:0]         shifter;
    logic [W-1:0]         next_shifter;
    logic                 next_busy;
    logic                 next_sdo_out;
    logic                 next_sdo_oe;
    logic                 next_track;
    logic                 next_nap;
    logic                 done;
    logic                 shift_en;

    // Both modes share one enable; in chain mode the pin carries data, so
    // the line is driven and shifted whatever level the pin shows.
    assign shift_en = sel_sync | ~pin_lvl; // RULE_03 RULE_04

    // Conversion sequencer and shift register.
    always_comb begin
        next_state    = state;
        next_trial    = trial;
        next_bit_mask = bit_mask;
        next_timer    = timer;
        next_step     = step;
        next_shifter  = shifter;
        done          = 1'b0;
        case (state)
            st_acquire: begin
                if (cnv_rise) begin                          // RULE_01
                    next_state    = st_convert;
                    next_bit_mask = {1'b1, {(W-1){1'b0}}};
                    next_trial    = {1'b1, {(W-1){1'b0}}};   // RULE_08
                    next_timer    = 10'h000;                 // RULE_10
                    next_step     = 2'h0;
                end
            end
            st_convert: begin
                next_timer = timer + 10'h001;
                if (step == 2'(`STEP_CYCLES - 1)) begin
                    next_step = 2'h0;
                    if (bit_mask != '0) begin
                        // Keep or drop the tested bit, then try the next.
                        next_trial = (comparator_high ? trial
                                      : trial & ~bit_mask)
                                     | (bit_mask >> 1);      // RULE_08
                        next_bit_mask = bit_mask >> 1;
                    end
                end else begin
                    next_step = step + 2'h1;
                end
                // The timer, not the search, fixes the conversion time.
                if (timer == 10'(CONV_CYC - 1)) begin        // RULE_10
                    next_state = st_acquire;
                    done       = 1'b1;
                end
            end
            default: next_state = st_acquire;
        endcase
        // Offset-binary search result to two's complement: flip the MSB.
        if (done) begin // RULE_09 RULE_11
            next_shifter = {~trial[W-1], trial[W-2:0]}; // RULE_06 RULE_07
        end else if (sck_rise && shift_en) begin // RULE_05 RULE_16
            // Cascade data enters behind the own word; a released output
            // keeps its word, so a later read still starts at the MSB.
            next_shifter = {shifter[W-2:0],
                            sel_sync & pin_lvl}; // RULE_19
        end
    end

    // Register the sequencer and the shift register.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state    <= st_acquire;
            trial    <= '0;
            bit_mask <= '0;
            timer    <= 10'h000;
            step     <= 2'h0;
            shifter  <= '0;
        end else begin
            state    <= next_state;
            trial    <= next_trial;
            bit_mask <= next_bit_mask;
            timer    <= next_timer;
            step     <= next_step;
            shifter  <= next_shifter;
        end
    end

    // Busy, track and nap follow the next sequencer state, so each
    // output leaves its flip-flop in the cycle in which that state begins.
    always_comb begin
        next_busy    = (next_state == st_convert);           // RULE_02
        next_track   = (next_state == st_acquire);           // RULE_13
        next_nap     = (next_state == st_acquire);           // RULE_12
        next_sdo_out = next_shifter[W-1];                    // RULE_17
        // Chain mode always drives; normal mode drives while pin is low.
        next_sdo_oe  = shift_en;                             // RULE_15 RULE_18
    end

    // Register the outputs.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            busy           <= 1'b0;
            track          <= 1'b1;
            nap            <= 1'b1;
            sdo_out        <= 1'b0;
            sdo_oe         <= 1'b0;
            capacitive_dac <= '0;
        end else begin
            busy           <= next_busy;
            track          <= next_track;
            nap            <= next_nap;
            sdo_out        <= next_sdo_out;
            sdo_oe         <= next_sdo_oe;
            capacitive_dac <= next_trial;
        end
    end
endmodule // sar_adc_ctrl

/* hdl/sar_adc_defs.svh */
// Timing and width constants for the converter control block.
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH
`define RESULT_WIDTH     18
`define CLK_PERIOD_NS    8
`define CONV_TIME_NS     460
`define CONV_CYCLES      ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_CYCLES      3
`endif

/* hdl/sar_adc_pkg.sv */
// Types shared by the converter control block.
package sar_adc_pkg;
    typedef enum logic [1:0] {
        st_acquire = 2'b00,
        st_convert = 2'b01
    } conv_state_t;
endpackage

/* hdl/edge_sync.sv */
// Two-stage synchroniser with rising-edge detection.
`timescale 1ns/1ps
module edge_sync (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic resetn,
    // Asynchronous input and its synchronised forms.
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);
    logic meta;
    logic sync;
    logic last;
    logic next_meta;
    logic next_sync;
    logic next_last;

    // The first stage feeds only the second stage.
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
        next_last = sync;
    end

    // Register the stages.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    // Outputs follow the synchronised level.
    assign level = sync;
    assign rise  = sync & ~last;
endmodule // edge_sync

/* bench/sar_adc_ctrl_properties.sv */
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module sar_adc_ctrl_properties (
    // Watched ports.
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        convert_strobe,
    input wire logic        cascade_select,
    input wire logic        read_enable_or_cascade_in,
    input wire logic        sck,
    input wire logic        comparator_high,
    input wire logic        sdo_out,
    input wire logic        sdo_oe,
    input wire logic        busy,
    input wire logic [17:0] capacitive_dac,
    input wire logic        track,
    input wire logic        nap
);
    logic [7:0] busy_cnt;
    // Counts busy cycles, because a repetition of 58 would be too long.
    always_ff @(posedge core_clk) begin
        busy_cnt <= (!resetn || !busy) ? 8'h00 : busy_cnt + 8'h01;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence start_req;
        $rose(convert_strobe) && !busy;
    endsequence
    sequence quiet_sck;
        (!sck && !busy)[*6];
    endsequence
    sequence released_idle;
        (!cascade_select && read_enable_or_cascade_in && !busy)[*8];
    endsequence
    busy_start_a: assert property (
        start_req |-> ##[2:5] $rose(busy))
        else $error("busy did not rise after a strobe");
    busy_len_a: assert property (
        $fell(busy) |-> busy_cnt == 8'h3a)
        else $error("busy length is not 58 cycles");
    conv_awake_a: assert property (
        busy |-> !track && !nap)
        else $error("tracking or napping during conversion");
    idle_nap_a: assert property (
        $fell(busy) |-> ##[0:2] track && nap)
        else $error("no return to tracking nap");
    first_trial_a: assert property (
        $rose(busy) |-> ##[0:3] capacitive_dac == 18'h20000)
        else $error("search did not start at the top bit");
    out_release_a: assert property (
        (!cascade_select && read_enable_or_cascade_in)[*5] |-> !sdo_oe)
        else $error("output driven while disabled");
    out_enable_a: assert property (
        (!cascade_select && !read_enable_or_cascade_in)[*5] |-> sdo_oe)
        else $error("output not driven while enabled");
    chain_drive_a: assert property (
        cascade_select[*5] |-> sdo_oe)
        else $error("output not driven in chain mode");
    bit_hold_a: assert property (
        quiet_sck |-> $stable(sdo_out))
        else $error("serial bit moved without a clock edge");
    shift_gate_a: assert property (
        released_idle |-> $stable(sdo_out))
        else $error("released output shifted its word");
endmodule // sar_adc_ctrl_properties

bind sar_adc_ctrl sar_adc_ctrl_properties chk (
    .core_clk(core_clk), .resetn(resetn), .convert_strobe(convert_strobe),
    .cascade_select(cascade_select), .sck(sck), .sdo_out(sdo_out),
    .read_enable_or_cascade_in(read_enable_or_cascade_in),
    .comparator_high(comparator_high), .sdo_oe(sdo_oe), .busy(busy),
    .capacitive_dac(capacitive_dac), .track(track), .nap(nap)
);

/* bench/host_model.sv */
// Host model: strobes conversions, clocks words out, acts as comparator.
`timescale 1ns/1ps
module host_model (
    // Clock and device outputs.
    input  wire logic        core_clk,
    input  wire logic        busy,
    input  wire logic        sdo_out,
    input  wire logic        sdo_oe,
    input  wire logic [17:0] capacitive_dac,
    // Host pins.
    output logic             convert_strobe = 1'b0,
    output logic             cascade_select = 1'b0,
    output logic             read_enable_or_cascade_in = 1'b1,
    output logic             sck = 1'b0,
    output logic             comparator_high
);
    logic [17:0] target = 18'h00000;
    logic        sdo_line;
    // The line has no pull-up, so a released output reads as the inverse.
    assign sdo_line = sdo_oe ? sdo_out : ~sdo_out;
    // A trial code at or below the held input keeps its bit.
    assign comparator_high = (capacitive_dac <= target);
    // Sets mode and pin, then lets the synchronisers settle.
    task automatic set_mode(input logic chain, input logic pin);
        @(posedge core_clk);
        cascade_select <= chain;
        read_enable_or_cascade_in <= pin;
        repeat (6) @(posedge core_clk);
    endtask
    // Starts a conversion; the serial clock stays low until busy falls.
    task automatic convert(input logic [17:0] level);
        int n;
        @(posedge core_clk);
        target <= level;
        convert_strobe <= 1'b1;
        repeat (8) @(posedge core_clk);
        convert_strobe <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    // Clocks bits out at 64 ns, feeding cascade bits ahead of each rise.
    task automatic shift(input int nbits, input logic [17:0] cin,
                         output logic [35:0] word);
        word = 36'h000000000;
        for (int i = 0; i < nbits; i++) begin
            @(posedge core_clk);
            if (cascade_select) begin
                read_enable_or_cascade_in <= (i < 18) ? cin[17 - i] : 1'b0;
            end
            repeat (3) @(posedge core_clk);
            word = {word[34:0], sdo_line};
            sck <= 1'b1;
            repeat (4) @(posedge core_clk);
            sck <= 1'b0;
        end
    endtask
endmodule // host_model

/* bench/sar_adc_ctrl_tb_top.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    n_fail++; $display("[ERR] %0t got %h want %h", $time, got, exp); end end
module sar_adc_ctrl_tb_top;
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    int          n_fail     = 0;
    int          n_compared = 0;
    logic        convert_strobe, cascade_select, rdl_pin, sck, cmp_high;
    logic        sdo_out, sdo_oe, busy, track, nap;
    logic [17:0] dac;
    always #4 core_clk = ~core_clk;
    sar_adc_ctrl dut (
        .core_clk(core_clk), .resetn(resetn), .convert_strobe(convert_strobe),
        .cascade_select(cascade_select), .read_enable_or_cascade_in(rdl_pin),
        .sck(sck), .comparator_high(cmp_high), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .busy(busy), .capacitive_dac(dac), .track(track),
        .nap(nap));
    host_model host (
        .core_clk(core_clk), .busy(busy), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .capacitive_dac(dac), .convert_strobe(convert_strobe),
        .cascade_select(cascade_select), .read_enable_or_cascade_in(rdl_pin),
        .sck(sck), .comparator_high(cmp_high));
    // Extreme and middle levels; the word is the level with its MSB flipped.
    task automatic test_normal();
        logic [17:0] lv [3] = '{18'h00000, 18'h20000, 18'h3ffff};
        logic [35:0] w;
        host.set_mode(1'b0, 1'b0);
        `CHK(sdo_oe, 1'b1)
        foreach (lv[k]) begin
            host.convert(lv[k]);
            `CHK(busy, 1'b0)
            host.shift(18, 18'h00000, w);
            `CHK(w[17:0], lv[k] ^ 18'h20000)
        end
        host.set_mode(1'b0, 1'b1);
        `CHK(sdo_oe, 1'b0)
        $display("test_normal done");
    endtask
    // A released output must neither drive the line nor shift its word.
    task automatic test_shared();
        logic [35:0] w;
        host.set_mode(1'b0, 1'b1);
        host.convert(18'h1e0f7);
        `CHK(busy, 1'b0)
        host.shift(5, 18'h00000, w);
        `CHK(w[4:0], 5'h00)
        host.set_mode(1'b0, 1'b0);
        host.shift(18, 18'h00000, w);
        `CHK(w[17:0], 18'h3e0f7)
        $display("test_shared done");
    endtask
    // Chain mode: upstream bits must follow the own word.
    task automatic test_chain();
        logic [35:0] w;
        host.set_mode(1'b1, 1'b0);
        `CHK(sdo_oe, 1'b1)
        host.convert(18'h0a5c3);
        `CHK(busy, 1'b0)
        host.shift(36, 18'h2d6b9, w);
        `CHK(w, {18'h2a5c3, 18'h2d6b9})
        $display("test_chain done");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence after a four-cycle reset.
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        test_normal();
        test_shared();
        test_chain();
        tally_and_finish();
    end
    // Watchdog: the tests need under 2000 cycles.
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule // sar_adc_ctrl_tb_top
